//--- hw/dcd_pkg.sv
/*
 * shared constants and types of the ddr command / clock-enable decoder.
 * assumes nothing of its surroundings; imported by the sync and core design files.
 */
package dcd_pkg;

   // data width straps
   localparam logic [1:0] DCD_W_X8   = 2'h0;
   localparam logic [1:0] DCD_W_X16  = 2'h1;
   localparam logic [1:0] DCD_W_X32  = 2'h2;

   // precharge flag position per width
   localparam int DCD_AP_BIT_X32  = 8;
   localparam int DCD_AP_BIT_X816 = 10;

   // mode register select on the bank address
   localparam logic [1:0] DCD_MR_BASE = 2'h0;
   localparam logic [1:0] DCD_MR_EXT  = 2'h1;

   // burst length field of the base mode register
   localparam int         DCD_BL_LSB  = 0;
   localparam logic [2:0] DCD_BL_2    = 3'h1;
   localparam logic [2:0] DCD_BL_4    = 3'h2;
   localparam logic [2:0] DCD_BL_8    = 3'h3;
   localparam logic [2:0] DCD_CYC_BL2 = 3'h1;
   localparam logic [2:0] DCD_CYC_BL4 = 3'h2;
   localparam logic [2:0] DCD_CYC_BL8 = 3'h4;

   // {ras_n, cas_n, we_n} with chip select low
   localparam logic [2:0] DCD_C_NOP = 3'h7;
   localparam logic [2:0] DCD_C_ACT = 3'h3;
   localparam logic [2:0] DCD_C_RD  = 3'h5;
   localparam logic [2:0] DCD_C_WR  = 3'h4;
   localparam logic [2:0] DCD_C_BST = 3'h6;
   localparam logic [2:0] DCD_C_PRE = 3'h2;
   localparam logic [2:0] DCD_C_REF = 3'h1;
   localparam logic [2:0] DCD_C_MRS = 3'h0;

   localparam int DCD_LANES = 4;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST,
      CMD_PRE, CMD_REF, CMD_MRS
   } dcd_cmd_e;

   typedef enum logic [1:0] {
      PW_ON, PW_PRE_PD, PW_ACT_PD, PW_SELF
   } dcd_pwr_e;

endpackage

//--- hw/dcd_sync_if.sv
/*
 * carrier for one synchroniser: word in from the source domain, word
 * out in the destination domain. assumes a quasi-static source word
 * or a toggle per event.
 */
`timescale 1ns/1ps
`default_nettype none
interface dcd_sync_if #(parameter int W = 1);
   logic [W-1:0] d;
   logic [W-1:0] q;
   modport sync (input d, output q);
   modport user (output d, input q);
endinterface
`default_nettype wire

//--- hw/dcd_sync.sv
/*
 * two-flop level synchroniser, one chain per bit.
 * assumes each bit is a level or a toggle that holds for two edges.
 */
`timescale 1ns/1ps
`default_nettype none
module dcd_sync
   import dcd_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic  clk,  // destination clock
   dcd_sync_if.sync  sif   // source word in, synced word out
);

   typedef struct packed {
      logic [W-1:0] m1;
      logic [W-1:0] m2;
   } dcd_sync_s;

   dcd_sync_s s_r;
   dcd_sync_s s_nxt;

   // no reset: this chain also carries the reset itself
   always_comb begin
      s_nxt    = s_r;
      s_nxt.m1 = sif.d;
      s_nxt.m2 = s_r.m1;
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   assign sif.q = s_r.m2;

endmodule
`default_nettype wire

//--- hw/dcd_core.sv
/*
 * command decoder and clock-enable power-state tracker of a four-bank
 * ddr sdram, with write-mask lane gating and strobe-to-lane mapping.
 * assumes the controller drives commands on link_clk rising edges and
 * keeps its own side of the protocol; status crosses to sys_clk.
 */
// How it works
// - command pins are sampled only at the link clock rising edge.
// - deselect and nop behave the same and start nothing.
// - activate opens the given row in the selected bank.
// - read starts a burst at the column; precharge flag adds precharge.
// - write starts a burst at the column; precharge flag adds precharge.
// - the precharge flag belongs only to its own read or write.
// - burst terminate ends a plain read; controller never uses it else.
// - precharge closes one bank, or all banks when the flag is high.
// - refresh with clock enable high, self-refresh entry when low.
// - refresh ignores address pins and uses an internal counter.
// - mode load writes base or extended register by bank address.
// - a write beat is stored only when its mask is low.
// - strobes map to byte lanes according to the data width.
// - power actions compare clock enable now against the last edge.
// - low clock enable holds power state; rise with nop exits.
// - fall with nop enters precharge or active power-down.
// - precharge flag is A8 on x32, A10 on x8 and x16.
// - chip select is part of the command; high decodes nothing.
`timescale 1ns/1ps
`default_nettype none
module dcd_core
   import dcd_pkg::*;
(
   input  wire logic        sys_clk,         // system clock
   input  wire logic        rst,             // sync reset, high
   input  wire logic        link_clk,        // memory clock, rising
   input  wire logic        cs_n,            // chip select, low
   input  wire logic        ras_n,           // row strobe, low
   input  wire logic        cas_n,           // column strobe, low
   input  wire logic        we_n,            // write strobe, low
   input  wire logic [1:0]  ba,              // bank address
   input  wire logic [12:0] addr,            // address bus
   input  wire logic        cke,             // clock enable
   input  wire logic [3:0]  dm,              // write mask per lane
   input  wire logic [1:0]  cfg_width,       // width strap, pin
   output logic             cmd_valid,       // accepted command pulse
   output dcd_cmd_e         cmd,             // accepted command
   output logic [1:0]       cmd_bank,        // its bank
   output logic [12:0]      cmd_addr,        // row or column
   output logic             cmd_ap,          // precharge flag used
   output logic             cmd_all,         // precharge of all banks
   output logic             illegal,         // illegal command pulse
   output logic [3:0]       bank_open,       // open row per bank
   output dcd_pwr_e         power_state,     // power state
   output logic             rd_active,       // read burst running
   output logic             wr_active,       // write burst running
   output logic [3:0]       lane_store,      // lane beat stored
   output logic [7:0]       lane_strobe,     // strobe index per lane
   output logic [12:0]      base_mode,       // base mode register
   output logic [12:0]      ext_mode,        // extended mode register
   output logic [1:0]       ref_bank,        // refresh bank counter
   output logic [12:0]      ref_row,         // refresh row counter
   output logic [3:0]       sys_bank_open,   // bank_open on sys_clk
   output dcd_pwr_e         sys_power_state, // power_state on sys_clk
   output logic             sys_illegal      // illegal pulse, sys_clk
);

   ////////////////////////////////////////////////////////////////////
   // crossings

   dcd_sync_if #(.W(3)) rx_if ();
   dcd_sync_if #(.W(7)) tx_if ();

   dcd_sync #(.W(3)) u_rx (
      .clk (link_clk),
      .sif (rx_if.sync)
   );

   dcd_sync #(.W(7)) u_tx (
      .clk (sys_clk),
      .sif (tx_if.sync)
   );

   logic       link_rst;
   logic [1:0] width;

   assign rx_if.d  = {rst, cfg_width};
   assign link_rst = rx_if.q[2];
   assign width    = rx_if.q[1:0];

   ////////////////////////////////////////////////////////////////////
   // link domain state

   typedef struct packed {
      logic        cke_prev;
      dcd_pwr_e    pwr;
      logic [3:0]  open;
      logic [2:0]  rd_left;
      logic [2:0]  wr_left;
      logic        ap_pend;
      logic [1:0]  ap_bank;
      logic        valid;
      dcd_cmd_e    cmd;
      logic [1:0]  bank;
      logic [12:0] addr;
      logic        ap;
      logic        all;
      logic        bad;
      logic        err_tgl;
      logic [12:0] base;
      logic [12:0] ext;
      logic [14:0] ref_cnt;
      logic [3:0]  store;
      logic [7:0]  lmap;
   } dcd_link_s;

   dcd_link_s l_r;
   dcd_link_s l_nxt;

   logic [2:0]  op;
   dcd_cmd_e    c;
   logic        ap_in;
   logic [12:0] col;
   logic        idle;
   logic        norm;
   logic [2:0]  bl_cyc;
   logic [7:0]  lmap_w;
   logic [3:0]  lane_en;

   assign op = {ras_n, cas_n, we_n};

   // chip select high and nop fold into one code
   always_comb begin
      c = CMD_NOP;
      if (!cs_n) begin
         if (op == DCD_C_ACT) begin
            c = CMD_ACT;
         end else if (op == DCD_C_RD) begin
            c = CMD_RD;
         end else if (op == DCD_C_WR) begin
            c = CMD_WR;
         end else if (op == DCD_C_BST) begin
            c = CMD_BST;
         end else if (op == DCD_C_PRE) begin
            c = CMD_PRE;
         end else if (op == DCD_C_REF) begin
            c = CMD_REF;
         end else if (op == DCD_C_MRS) begin
            c = CMD_MRS;
         end
      end
   end

   always_comb begin
      col = addr;
      if (width == DCD_W_X32) begin
         ap_in                = addr[DCD_AP_BIT_X32];
         col[DCD_AP_BIT_X32]  = 1'b0;
      end else begin
         ap_in                = addr[DCD_AP_BIT_X816];
         col[DCD_AP_BIT_X816] = 1'b0;
      end
   end

   always_comb begin
      case (l_r.base[DCD_BL_LSB +: 3])
         DCD_BL_4: bl_cyc = DCD_CYC_BL4;
         DCD_BL_8: bl_cyc = DCD_CYC_BL8;
         default:  bl_cyc = DCD_CYC_BL2;
      endcase
   end

   assign idle = (l_r.open == 4'h0) && !l_r.ap_pend;
   assign norm = cke && l_r.cke_prev && (l_r.pwr == PW_ON);

   // lanes beyond the part's width carry no strobe and store nothing
   for (genvar i = 0; i < DCD_LANES; i++) begin : g_lane
      assign lane_en[i] = (width == DCD_W_X32) ||
                          ((width == DCD_W_X16) && (i < 2)) || (i == 0);
      assign lmap_w[2*i +: 2] = lane_en[i] ? 2'(i) : 2'h0;
   end

   always_comb begin
      l_nxt          = l_r;
      l_nxt.cke_prev = cke;
      l_nxt.valid    = 1'b0;
      l_nxt.bad      = 1'b0;
      l_nxt.lmap     = lmap_w;
      l_nxt.store    = (l_r.wr_left != 3'h0) ? (~dm & lane_en) : 4'h0;
      if (l_r.rd_left != 3'h0) begin
         l_nxt.rd_left = l_r.rd_left - 3'h1;
      end
      if (l_r.wr_left != 3'h0) begin
         l_nxt.wr_left = l_r.wr_left - 3'h1;
      end
      // auto precharge fires once the burst it rode on drains
      if (l_r.ap_pend && ((l_r.rd_left | l_r.wr_left) == 3'h1)) begin
         l_nxt.ap_pend          = 1'b0;
         l_nxt.open[l_r.ap_bank] = 1'b0;
      end
      if (!l_r.cke_prev && !cke) begin
         l_nxt.pwr = l_r.pwr;
      end else if (!l_r.cke_prev && l_r.pwr != PW_ON) begin
         if (c == CMD_NOP) begin
            l_nxt.pwr = PW_ON;
         end else begin
            l_nxt.bad = 1'b1;
         end
      end else if (l_r.cke_prev && !cke) begin
         if (c == CMD_NOP) begin
            l_nxt.pwr = (l_r.open == 4'h0) ? PW_PRE_PD : PW_ACT_PD;
         end else if (c == CMD_REF && idle) begin
            l_nxt.pwr = PW_SELF;
         end else begin
            l_nxt.bad = 1'b1;
         end
      end else if (cke) begin
         l_nxt.cmd  = c;
         l_nxt.bank = ba;
         l_nxt.addr = addr;
         l_nxt.ap   = 1'b0;
         l_nxt.all  = 1'b0;
         case (c)
            CMD_NOP: begin
            end
            CMD_ACT: begin
               if (l_r.open[ba]) begin
                  l_nxt.bad = 1'b1;
               end else begin
                  l_nxt.open[ba] = 1'b1;
                  l_nxt.valid    = 1'b1;
               end
            end
            CMD_RD, CMD_WR: begin
               if (!l_r.open[ba] || l_r.ap_pend) begin
                  l_nxt.bad = 1'b1;
               end else begin
                  l_nxt.valid   = 1'b1;
                  l_nxt.addr    = col;
                  l_nxt.ap      = ap_in;
                  l_nxt.ap_pend = ap_in;
                  l_nxt.ap_bank = ba;
                  l_nxt.rd_left = (c == CMD_RD) ? bl_cyc : 3'h0;
                  l_nxt.wr_left = (c == CMD_WR) ? bl_cyc : 3'h0;
               end
            end
            CMD_BST: begin
               if (l_r.rd_left == 3'h0 || l_r.ap_pend) begin
                  l_nxt.bad = 1'b1;
               end else begin
                  l_nxt.valid   = 1'b1;
                  l_nxt.rd_left = 3'h0;
               end
            end
            CMD_PRE: begin
               l_nxt.valid = 1'b1;
               l_nxt.ap    = ap_in;
               l_nxt.all   = ap_in;
               if (ap_in) begin
                  l_nxt.open = 4'h0;
               end else begin
                  l_nxt.open[ba] = 1'b0;
               end
            end
            CMD_REF: begin
               if (!idle) begin
                  l_nxt.bad = 1'b1;
               end else begin
                  l_nxt.valid   = 1'b1;
                  l_nxt.bank    = l_r.ref_cnt[14:13];
                  l_nxt.addr    = l_r.ref_cnt[12:0];
                  l_nxt.ref_cnt = l_r.ref_cnt + 15'h1;
               end
            end
            CMD_MRS: begin
               if (!idle || ba[1]) begin
                  l_nxt.bad = 1'b1;
               end else begin
                  l_nxt.valid = 1'b1;
                  if (ba == DCD_MR_BASE) begin
                     l_nxt.base = addr;
                  end else if (ba == DCD_MR_EXT) begin
                     l_nxt.ext = addr;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (l_nxt.bad) begin
         l_nxt.err_tgl = !l_r.err_tgl;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   assign cmd_valid   = l_r.valid;
   assign cmd         = l_r.cmd;
   assign cmd_bank    = l_r.bank;
   assign cmd_addr    = l_r.addr;
   assign cmd_ap      = l_r.ap;
   assign cmd_all     = l_r.all;
   assign illegal     = l_r.bad;
   assign bank_open   = l_r.open;
   assign power_state = l_r.pwr;
   assign rd_active   = l_r.rd_left != 3'h0;
   assign wr_active   = l_r.wr_left != 3'h0;
   assign lane_store  = l_r.store;
   assign lane_strobe = l_r.lmap;
   assign base_mode   = l_r.base;
   assign ext_mode    = l_r.ext;
   assign ref_bank    = l_r.ref_cnt[14:13];
   assign ref_row     = l_r.ref_cnt[12:0];

   ////////////////////////////////////////////////////////////////////
   // system domain status

   typedef struct packed {
      logic [3:0] open;
      dcd_pwr_e   pwr;
      logic       tgl;
      logic       err;
   } dcd_sys_s;

   dcd_sys_s s_r;
   dcd_sys_s s_nxt;

   // the error event rides as a toggle so no pulse is lost
   assign tx_if.d = {l_r.open, l_r.pwr, l_r.err_tgl};

   always_comb begin
      s_nxt      = s_r;
      s_nxt.open = tx_if.q[6:3];
      s_nxt.pwr  = dcd_pwr_e'(tx_if.q[2:1]);
      s_nxt.tgl  = tx_if.q[0];
      s_nxt.err  = tx_if.q[0] ^ s_r.tgl;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sys_bank_open   = s_r.open;
   assign sys_power_state = s_r.pwr;
   assign sys_illegal     = s_r.err;

   ////////////////////////////////////////////////////////////////////
   // checks

   a_nop_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
      (norm && c == CMD_NOP && !l_r.ap_pend)
      |=> !l_r.valid && $stable(l_r.open))
      else $error("nop changed state");

   a_act_opens: assert property (@(posedge link_clk) disable iff (link_rst)
      (norm && c == CMD_ACT && !l_r.open[ba])
      |=> l_r.open[$past(ba)] && l_r.valid && l_r.addr == $past(addr))
      else $error("activate did not open bank");

   a_rd_burst: assert property (@(posedge link_clk) disable iff (link_rst)
      (norm && c == CMD_RD && l_r.open[ba] && !l_r.ap_pend)
      |=> l_r.rd_left != 3'h0 && l_r.ap == $past(ap_in))
      else $error("read burst not started");

   a_wr_burst: assert property (@(posedge link_clk) disable iff (link_rst)
      (norm && c == CMD_WR && l_r.open[ba] && !l_r.ap_pend)
      |=> l_r.wr_left != 3'h0 ##[1:4] l_r.wr_left == 3'h0)
      else $error("write burst wrong");

   a_bst_stop: assert property (@(posedge link_clk) disable iff (link_rst)
      (norm && c == CMD_BST && l_r.rd_left > 3'h1 && !l_r.ap_pend)
      |=> l_r.rd_left == 3'h0)
      else $error("burst terminate ignored");

   a_pre_all: assert property (@(posedge link_clk) disable iff (link_rst)
      (norm && c == CMD_PRE && ap_in) |=> l_r.open == 4'h0 && l_r.all)
      else $error("precharge all left a bank open");

   a_self_entry: assert property (@(posedge link_clk) disable iff (link_rst)
      (l_r.cke_prev && !cke && c == CMD_REF && idle)
      |=> l_r.pwr == PW_SELF ##1 (!l_r.cke_prev && !cke)[*1]
      |=> l_r.pwr == PW_SELF)
      else $error("self-refresh not entered");

   a_pd_entry: assert property (@(posedge link_clk) disable iff (link_rst)
      (l_r.cke_prev && !cke && c == CMD_NOP && l_r.open != 4'h0)
      |=> l_r.pwr == PW_ACT_PD)
      else $error("active power-down not entered");

   a_pd_hold: assert property (@(posedge link_clk) disable iff (link_rst)
      (!l_r.cke_prev && !cke) |=> l_r.pwr == $past(l_r.pwr))
      else $error("power state moved with clock enable low");

   a_bad_keep: assert property (@(posedge link_clk) disable iff (link_rst)
      l_nxt.bad |=> l_r.bad && !l_r.valid)
      else $error("illegal command accepted");

   a_mask_lane: assert property (@(posedge link_clk) disable iff (link_rst)
      (l_r.wr_left != 3'h0 && dm[0]) |=> !l_r.store[0])
      else $error("masked beat stored");

endmodule
`default_nettype wire

//--- bench/dcd_ctrl_model.sv
/*
 * controller model on the link side of the command decoder.
 * assumes the bench calls its tasks by hierarchical name.
 */
`timescale 1ns/1ps
`default_nettype none
module dcd_ctrl_model
   import dcd_pkg::*;
#(
   parameter int SRX = 4  // exit and settle nops, plain default
) (
   input  wire logic        link_clk, // memory clock
   output logic             cs_n,     // chip select, low
   output logic [2:0]       rcw,      // row, column, write strobes
   output logic [1:0]       ba,       // bank address
   output logic [12:0]      addr,     // address bus
   output logic             cke,      // clock enable
   output logic [3:0]       dm        // write mask
);
   initial begin
      cs_n = 1'b0;
      rcw  = DCD_C_NOP;
      ba   = 2'h0;
      addr = 13'h0000;
      cke  = 1'b1;
      dm   = 4'hf;
   end
   // don't-care pins flip each cycle so stale values never look live
   task automatic idle();
      @(negedge link_clk);
      cs_n <= 1'b0;
      rcw  <= DCD_C_NOP;
      ba   <= ~ba;
      addr <= ~addr;
   endtask
   task automatic desel(input logic [2:0] c, input logic [12:0] a);
      @(negedge link_clk);
      cs_n <= 1'b1;
      rcw  <= c;
      addr <= a;
   endtask
   task automatic issue(input logic [2:0] c, input logic [1:0] b,
                        input logic [12:0] a, input logic k,
                        input logic [3:0] m);
      logic was;
      was = cke;
      if (was && !k)
         repeat (6) idle();
      @(negedge link_clk);
      cs_n <= 1'b0;
      rcw  <= c;
      ba   <= b;
      addr <= a;
      cke  <= k;
      dm   <= m;
      if (!was && k)
         repeat (SRX) idle();
      if (c == DCD_C_MRS)
         repeat (SRX) idle();
   endtask
endmodule
`default_nettype wire

//--- bench/ddr_sdram_command_cke_decode_tb.sv
/*
 * bench of the command decoder: the model drives the link, expected
 * responses are queued and a monitor checks them at link_clk falls.
 * assumes package and design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_command_cke_decode_tb
   import dcd_pkg::*;
;
   localparam logic [20:0] MF = 21'h1fffff;
   localparam logic [20:0] MA = 21'h1ffffe;
   localparam logic [20:0] MB = 21'h1fc001;
   localparam logic [20:0] MC = 21'h1f0000;
   localparam logic [20:0] MI = 21'h100000;
   localparam logic [7:0]  LS [3] = '{8'h00, 8'h04, 8'he4};
   logic        sys_clk, link_clk, rst, cs_n, cke, loose, rd_active;
   logic        wr_active;
   logic [2:0]  rcw;
   logic [1:0]  ba, cfg_width, cmd_bank, ref_bank, b;
   logic [12:0] addr, cmd_addr, base_mode, ext_mode, ref_row, r;
   logic [3:0]  dm, wm, bank_open, lane_store, sys_bank_open;
   logic        cmd_valid, cmd_ap, cmd_all, illegal, sys_illegal, hit;
   dcd_cmd_e    cmd;
   dcd_pwr_e    power_state, sys_power_state;
   logic [7:0]  lane_strobe;
   logic [14:0] rc;
   logic [41:0] expq[$];
   logic [41:0] e;
   logic [31:0] seed = 32'h0000794f;
   int          n_fail = 0, samples_checked = 0, n_sysill = 0;
   dcd_core DUT (
      .sys_clk, .rst, .link_clk, .cs_n, .ras_n(rcw[2]), .cas_n(rcw[1]),
      .we_n(rcw[0]), .ba, .addr, .cke, .dm, .cfg_width, .cmd_valid, .cmd,
      .cmd_bank, .cmd_addr, .cmd_ap, .cmd_all, .illegal, .bank_open,
      .power_state, .rd_active, .wr_active, .lane_store, .lane_strobe,
      .base_mode, .ext_mode, .ref_bank, .ref_row, .sys_bank_open,
      .sys_power_state, .sys_illegal
   );
   dcd_ctrl_model #(.SRX(4)) m0 (
      .link_clk, .cs_n, .rcw, .ba, .addr, .cke, .dm
   );
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [20:0] x, y);
      samples_checked++;
      if (y !== x) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, x, y);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) m0.idle();
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // note first, so the monitor never meets a response before its note
   task automatic go(input logic [2:0] c, input dcd_cmd_e ec,
                     input logic [1:0] bk, input logic [12:0] a,
                     input logic ap, input logic [20:0] mk);
      expq.push_back({mk, {mk == MI, ec, bk, a, ap} & mk});
      m0.issue(c, bk, a | {4'h0, ap, 8'h00}, 1'b1, wm);
   endtask
   task automatic pw(input logic [2:0] c, input logic k, input dcd_pwr_e s);
      m0.issue(c, 2'(rnd()), 13'(rnd()), k, 4'hf);
      wt(2);
      chk("power state", {19'h0, s}, {19'h0, power_state});
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(negedge link_clk) begin
      if (!rst && (cmd_valid === 1'b1 || illegal === 1'b1)) begin
         if (expq.size() == 0) begin
            if (!loose) begin
               n_fail++;
               $display("Error response expected none seen %h", cmd);
            end
         end else begin
            e = expq.pop_front();
            chk("response", e[20:0],
                {illegal, cmd, cmd_bank, cmd_addr, cmd_ap} & e[41:21]);
         end
      end
   end
   // each illegal command must reach the system side as one pulse
   always @(posedge sys_clk) begin
      if (!rst && sys_illegal === 1'b1)
         n_sysill++;
   end
   initial begin
      #50000;
      n_fail++;
      end_of_test();
   end
   initial begin : main
      rst = 1'b1;
      cfg_width = DCD_W_X32;
      loose = 1'b0;
      wm = 4'h0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      wt(4);
      // burst of eight, so a terminate can land inside a read
      go(DCD_C_MRS, CMD_MRS, DCD_MR_BASE, 13'h0003, 1'b0, MA);
      r = 13'(rnd());
      go(DCD_C_MRS, CMD_MRS, DCD_MR_EXT, r, 1'b0, MA);
      go(DCD_C_MRS, CMD_MRS, 2'h2, ~r, 1'b0, MI);
      wt(2);
      chk("base mode", 21'h3, {8'h0, base_mode});
      chk("ext mode", {8'h0, r}, {8'h0, ext_mode});
      done("mode");
      b = 2'(rnd());
      go(DCD_C_ACT, CMD_ACT, b, 13'(rnd()), 1'b0, MA);
      r = 13'(rnd()) & 13'h00ff;
      go(DCD_C_RD, CMD_RD, b, r, 1'b0, MF);
      m0.idle();
      go(DCD_C_BST, CMD_BST, b, r, 1'b0, MC);
      wt(3);
      chk("read ended", 21'h0, {20'h0, rd_active});
      wm = 4'(rnd());
      go(DCD_C_WR, CMD_WR, b, r, 1'b1, MF);
      @(posedge link_clk);
      #1;
      chk("write running", 21'h1, {20'h0, wr_active});
      hit = 1'b0;
      repeat (8) begin
         m0.idle();
         hit |= (lane_store === ~wm);
         chk("masked lanes", 21'h0, {17'h0, lane_store & wm});
      end
      chk("stored lanes", 21'h1, {20'h0, hit});
      chk("auto close", 21'h0, {20'h0, bank_open[b]});
      go(DCD_C_RD, CMD_RD, b, r, 1'b0, MI);
      go(DCD_C_ACT, CMD_ACT, b, 13'(rnd()), 1'b0, MA);
      go(DCD_C_RD, CMD_RD, b, r, 1'b0, MF);
      wt(8);
      chk("flag dropped", 21'h1, {20'h0, bank_open[b]});
      done("burst");
      go(DCD_C_PRE, CMD_PRE, b, 13'h0, 1'b0, MB);
      for (int i = 0; i < 4; i++)
         go(DCD_C_ACT, CMD_ACT, 2'(i), 13'(rnd()), 1'b0, MA);
      go(DCD_C_PRE, CMD_PRE, 2'h2, 13'h0, 1'b0, MB);
      wt(2);
      chk("one closed", 21'hb, {17'h0, bank_open});
      go(DCD_C_PRE, CMD_PRE, 2'(rnd()), 13'h0, 1'b1, 21'h1f0001);
      // the flag stands only until the next nop is registered
      @(posedge link_clk);
      #1;
      chk("all flag", 21'h1, {20'h0, cmd_all});
      wt(2);
      chk("all closed", 21'h0, {17'h0, bank_open});
      rc = {ref_bank, ref_row};
      go(DCD_C_REF, CMD_REF, 2'(rnd()), 13'(rnd()), 1'b0, MC);
      wt(2);
      chk("refresh counter", {6'h0, rc + 15'h1}, {6'h0, ref_bank, ref_row});
      for (int i = 0; i < 8; i++)
         m0.desel(3'(rnd()), 13'(rnd()));
      wt(2);
      chk("deselected", 21'h0, {17'h0, bank_open});
      done("precharge refresh");
      loose = 1'b1;
      pw(DCD_C_NOP, 1'b0, PW_PRE_PD);
      pw(3'(rnd()), 1'b0, PW_PRE_PD);
      pw(DCD_C_NOP, 1'b1, PW_ON);
      go(DCD_C_ACT, CMD_ACT, 2'h3, 13'(rnd()), 1'b0, MA);
      pw(DCD_C_NOP, 1'b0, PW_ACT_PD);
      pw(DCD_C_NOP, 1'b1, PW_ON);
      go(DCD_C_PRE, CMD_PRE, 2'h3, 13'h0, 1'b0, MB);
      pw(DCD_C_REF, 1'b0, PW_SELF);
      repeat (10) @(negedge sys_clk);
      chk("sys power", {19'h0, PW_SELF}, {19'h0, sys_power_state});
      chk("sys banks", 21'h0, {17'h0, sys_bank_open});
      pw(DCD_C_NOP, 1'b1, PW_ON);
      loose = 1'b0;
      done("power");
      for (int w = 2; w >= 0; w--) begin
         @(negedge sys_clk);
         cfg_width = 2'(w);
         wt(12);
         chk("lane strobes", {13'h0, LS[w]}, {13'h0, lane_strobe});
      end
      done("lanes");
      wt(4);
      chk("notes left", 21'h0, 21'(expq.size()));
      chk("sys illegal", 21'h2, 21'(n_sysill));
      end_of_test();
   end
endmodule
`default_nettype wire
